// ### rtl/nv_access_consts.svh
// Constants for the nonvolatile data array access controller
`ifndef NV_ACCESS_CONSTS_SVH
`define NV_ACCESS_CONSTS_SVH

// Register selects on the special function register port
`define NV_SEL_CTRL 3'h0
`define NV_SEL_KEY 3'h1
`define NV_SEL_ADRH 3'h2
`define NV_SEL_ADRL 3'h3
`define NV_SEL_DATA 3'h4

// Bit positions in memory_access_control
`define NV_B_PGD 7
`define NV_B_CFG 6
`define NV_B_ROW 4
`define NV_B_ERR 3
`define NV_B_WRITE_ENABLE 2
`define NV_B_WR 1
`define NV_B_RD 0

// Unlock keys
`define NV_KEY_FIRST 8'h55
`define NV_KEY_SECOND 8'haa

// Reset value of the error flag, and erased byte value
`define NV_ERR_RST 1'b1
`define NV_ERASED_BYTE 8'hff

// Timing
`define NV_CLK_PERIOD_NS 4
`define NV_WRITE_TIME_NS 4000000
`define NV_PWRT_TIME_NS 65536
`define NV_WRITE_CYCLES (`NV_WRITE_TIME_NS / `NV_CLK_PERIOD_NS)
`define NV_PWRT_CYCLES (`NV_PWRT_TIME_NS / `NV_CLK_PERIOD_NS)

`endif

// ### rtl/nv_access_ctrl.sv
// Access controller for the 1024-byte nonvolatile data array
//
// Overview of operation
// - program_space_select 0 targets the data array, 1 targets program flash.
// - config_space_select 1 targets configuration space, overriding the other.
// - Address is 10 bits; only two low bits of the high register used.
// - Each access moves one byte through the data byte register.
// - A byte write erases the location first, then programs it.
// - Write cycle length comes from an internal timer.
// - Writes need write_enable set; reset clears write_enable.
// - Setting write_enable sets the error flag; normal completion clears it.
// - Error flag 1 means aborted or improper write; 0 means completed.
// - Space select bits keep their values when an error is recorded; reset sets the error flag but clears both.
// - write_start is set-only by software, cleared by hardware at end.
// - Device sets write_done_flag at write end; software clears it.
// - read_start launches a one-cycle read, then clears itself.
// - read_start cannot be set while either space select bit is 1.
// - Unlock port stores nothing and reads as zero.
// - Read data appears next cycle and stays until next read or write.
// - row_erase_enable makes the next write only run the timer, leaving the array unchanged; cleared after.
// - Program flash writes need the same unlock sequence.
// - Unused control bit 5 reads zero.
// - Write starts only after 55h, AAh to unlock port, then write_start.
// - write_enable must be set by an earlier write than write_start.
// - Control, address and data registers are frozen during a write.
// - Writes are blocked during the power-up timer period.
`include "nv_access_consts.svh"
`default_nettype none
module nv_access_ctrl
  import nv_access_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = `NV_WRITE_CYCLES,
  parameter int unsigned PWRT_CYCLES = `NV_PWRT_CYCLES
) (
  input wire logic core_clk, // Instruction clock
  input wire logic rst_n, // Power-on reset, async, active low
  input wire logic [2:0] regSel, // Register select
  input wire logic regWr, // Register write strobe
  input wire logic [7:0] regWdata, // Register write data
  output logic [7:0] regRdata, // Data of register selected last cycle
  input wire logic doneClr, // Software clear of write_done_flag
  output logic writeDoneFlag, // write_done_flag
  output logic writeBusy, // Self-timed cycle in progress
  output logic [1:0] spaceSel // {program_space_select, config_space_select}
);

  // Each phase of a write is half of the programming time
  localparam logic [19:0] HALF_M1 = 20'(WRITE_CYCLES / 2 - 1);
  localparam logic [19:0] PWRT_M1 = 20'(PWRT_CYCLES - 1);

  state_t q;
  state_t d;
  logic [7:0] mem [0:1023];
  logic memWe;
  logic [7:0] memWd;
  logic [9:0] addr;
  logic [7:0] rdByte;
  logic busy;
  logic dataTarget;
  logic ctrlWr;
  logic newPgd;
  logic newCfg;

  function automatic logic [7:0] readMux(input logic [2:0] sel,
                                         input state_t s);
    logic [7:0] v;
    v = 8'h00;
    if (sel == `NV_SEL_CTRL) begin
      v = {s.pgd, s.cfg, 1'b0, s.rowErase, s.err, s.write_enable, s.wr, s.rd};
    end else if (sel == `NV_SEL_ADRH) begin
      v = {6'h00, s.adrHi};
    end else if (sel == `NV_SEL_ADRL) begin
      v = s.adrLo;
    end else if (sel == `NV_SEL_DATA) begin
      v = s.data;
    end else begin
      v = 8'h00;
    end
    return v;
  endfunction

  assign addr = {q.adrHi, q.adrLo};
  assign rdByte = mem[addr];
  assign busy = (q.wst != WIDLE);
  assign dataTarget = !q.pgd && !q.cfg;
  assign ctrlWr = regWr && (regSel == `NV_SEL_CTRL) && !busy;
  assign newPgd = regWdata[`NV_B_PGD];
  assign newCfg = regWdata[`NV_B_CFG];

  always_comb begin
    d = q;
    memWe = 1'b0;
    memWd = 8'h00;
    d.rd = 1'b0;
    if (q.rd) begin
      d.data = rdByte;
    end
    if (doneClr) begin
      d.done = 1'b0;
    end
    if (!q.pwrtDone) begin
      d.pwrt = q.pwrt + 20'h00001;
      if (q.pwrt == PWRT_M1) begin
        d.pwrtDone = 1'b1;
      end
    end
    case (q.wst)
      WERASE: begin
        if (q.tmr == 20'h00000) begin
          // Row erase and flash targets only run the timer here
          memWe = dataTarget && !q.rowErase;
          memWd = `NV_ERASED_BYTE;
          d.wst = WPROG;
          d.tmr = HALF_M1;
        end else begin
          d.tmr = q.tmr - 20'h00001;
        end
      end
      WPROG: begin
        if (q.tmr == 20'h00000) begin
          memWe = dataTarget && !q.rowErase;
          memWd = q.data;
          d.wst = WIDLE;
          d.wr = 1'b0;
          d.err = 1'b0;
          d.done = 1'b1;
          d.rowErase = 1'b0;
        end else begin
          d.tmr = q.tmr - 20'h00001;
        end
      end
      default: begin
      end
    endcase
    if (regWr) begin
      d.kst = KIDLE;
      if (regSel == `NV_SEL_KEY) begin
        if (q.kst == KIDLE && regWdata == `NV_KEY_FIRST) begin
          d.kst = KGOT1;
        end else if (q.kst == KGOT1 && regWdata == `NV_KEY_SECOND) begin
          d.kst = KARMED;
        end
      end else if (ctrlWr) begin
        // Space selects move only on a control write; reset sets the error flag and clears both
        d.pgd = newPgd;
        d.cfg = newCfg;
        d.rowErase = regWdata[`NV_B_ROW];
        d.write_enable = regWdata[`NV_B_WRITE_ENABLE];
        d.err = regWdata[`NV_B_ERR];
        if (regWdata[`NV_B_WRITE_ENABLE] && !q.write_enable) begin
          d.err = 1'b1;
        end
        // A read already running still ends this cycle; only a new set counts
        d.rd = regWdata[`NV_B_RD] && !newPgd && !newCfg;
        if (regWdata[`NV_B_WR]) begin
          // Enable must predate this write: old write_enable, not the new one
          if (q.kst == KARMED && q.write_enable && q.pwrtDone) begin
            d.wr = 1'b1;
            d.wst = WERASE;
            d.tmr = HALF_M1;
          end else begin
            d.err = 1'b1;
          end
        end
      end else if (regSel == `NV_SEL_ADRH && !busy) begin
        d.adrHi = regWdata[1:0];
      end else if (regSel == `NV_SEL_ADRL && !busy) begin
        d.adrLo = regWdata;
      end else if (regSel == `NV_SEL_DATA && !busy) begin
        d.data = regWdata;
      end
    end
    d.rdata = readMux(regSel, q);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.err <= `NV_ERR_RST;
      q.write_enable <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // Array content is not reset; it models nonvolatile storage
  always_ff @(posedge core_clk) begin
    if (memWe) begin
      mem[addr] <= memWd;
    end
  end

  assign regRdata = q.rdata;
  assign writeDoneFlag = q.done;
  assign writeBusy = q.wr;
  assign spaceSel = {q.pgd, q.cfg};

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence eraseEnd;
    q.wst == WERASE && q.tmr == 20'h00000;
  endsequence

  sequence progEnd;
    q.wst == WPROG && q.tmr == 20'h00000;
  endsequence

  sequence writeGo;
    ctrlWr && regWdata[`NV_B_WR] && q.kst == KARMED && q.write_enable && q.pwrtDone;
  endsequence

  a_erase_then_prog: assert property (
    eraseEnd |=> q.wst == WPROG && q.tmr == HALF_M1 && q.wr)
    else $error("erase phase did not hand over to program");

  a_write_completes: assert property (
    progEnd |=> !q.wr && q.done && !q.err && q.wst == WIDLE)
    else $error("write end did not clear start and flag done");

  a_read_one_cycle: assert property (
    q.rd && !(ctrlWr && regWdata[`NV_B_RD]) |=> !q.rd)
    else $error("read_start stayed set");

  a_read_data_next: assert property (
    q.rd && !(regWr && regSel == `NV_SEL_DATA)
      |=> q.data == $past(rdByte))
    else $error("read data missing next cycle");

  a_read_refused: assert property (
    ctrlWr && (newPgd || newCfg) && !q.rd |=> !q.rd)
    else $error("read_start set with a space select high");

  a_unarmed_blocked: assert property (
    ctrlWr && regWdata[`NV_B_WR] && q.kst != KARMED
      |=> q.wst == WIDLE && q.err)
    else $error("write started without unlock");

  a_write_enable_prior: assert property (
    ctrlWr && regWdata[`NV_B_WR] && !q.write_enable |=> q.wst == WIDLE)
    else $error("write started without earlier enable");

  a_err_on_enable: assert property (
    ctrlWr && regWdata[`NV_B_WRITE_ENABLE] && !q.write_enable |=> q.err)
    else $error("error flag not set on enable");

  a_busy_freeze: assert property (
    busy && regWr |=> q.adrLo == $past(q.adrLo)
      && q.adrHi == $past(q.adrHi) && q.pgd == $past(q.pgd))
    else $error("registers changed during write");

  a_pwrt_block: assert property (
    !q.pwrtDone |-> q.wst == WIDLE)
    else $error("write during power-up timer");

  a_key_zero: assert property (
    regSel == `NV_SEL_KEY |=> regRdata == 8'h00)
    else $error("unlock port read nonzero");

  a_bit5_zero: assert property (
    regSel == `NV_SEL_CTRL |=> regRdata[5] == 1'b0)
    else $error("unused control bit read one");

  a_done_set_wins: assert property (
    progEnd ##0 doneClr |=> writeDoneFlag)
    else $error("done clear beat the set");

  a_bad_key_idle: assert property (
    regWr && regSel != `NV_SEL_KEY && !ctrlWr |=> q.kst == KIDLE)
    else $error("unlock detector not reset");

  a_write_start: assert property (
    writeGo |=> q.wst == WERASE && q.wr && q.tmr == HALF_M1)
    else $error("armed start did not begin the erase phase");

  a_key_consumed: assert property (
    writeGo |=> q.kst == KIDLE)
    else $error("unlock stayed armed after a start");

  a_key_first: assert property (
    regWr && regSel == `NV_SEL_KEY && q.kst == KIDLE
      && regWdata == `NV_KEY_FIRST |=> q.kst == KGOT1)
    else $error("first key not taken");

  a_key_second: assert property (
    regWr && regSel == `NV_SEL_KEY && q.kst == KGOT1
      && regWdata == `NV_KEY_SECOND |=> q.kst == KARMED)
    else $error("second key did not arm");

  a_write_enable_gate: assert property (
    !q.write_enable && !busy |=> !busy)
    else $error("write began with write_enable clear");

  a_space_hold: assert property (
    !ctrlWr |=> q.pgd == $past(q.pgd) && q.cfg == $past(q.cfg))
    else $error("space select moved without a control write");

  a_space_write: assert property (
    ctrlWr |=> spaceSel == {$past(newPgd), $past(newCfg)})
    else $error("space select not taken from control write");

  a_adr_high: assert property (
    regWr && regSel == `NV_SEL_ADRH && !busy
      |=> q.adrHi == $past(regWdata[1:0]))
    else $error("high address bits not taken");

  a_data_write: assert property (
    regWr && regSel == `NV_SEL_DATA && !busy |=> q.data == $past(regWdata))
    else $error("data byte write lost");

  a_data_hold: assert property (
    !q.rd && !(regWr && regSel == `NV_SEL_DATA && !busy)
      |=> q.data == $past(q.data))
    else $error("data byte changed without read or write");

  a_row_clear: assert property (
    progEnd |=> !q.rowErase)
    else $error("row erase bit kept after completion");

  a_flash_untouched: assert property (
    !dataTarget |-> !memWe)
    else $error("array written while another space selected");

  a_timer_step: assert property (
    busy && q.tmr != 20'h00000
      |=> busy && q.tmr == $past(q.tmr) - 20'h00001)
    else $error("programming timer did not count down");

  a_err_sticky: assert property (
    q.err && !ctrlWr && !(q.wst == WPROG && q.tmr == 20'h00000)
      |=> q.err)
    else $error("error flag cleared outside write end");

  a_wr_sticky: assert property (
    q.wr && !(q.wst == WPROG && q.tmr == 20'h00000) |=> q.wr)
    else $error("write_start cleared before the cycle ended");

  a_done_sticky: assert property (
    q.done && !doneClr |=> q.done)
    else $error("write_done_flag dropped without a clear");

  a_read_space: assert property (
    q.rd |-> !q.pgd && !q.cfg)
    else $error("read ran with a space select high");

endmodule // nv_access_ctrl
`default_nettype wire

// ### rtl/nv_access_pkg.sv
// Types for the nonvolatile data array access controller
`default_nettype none
package nv_access_pkg;

  typedef enum logic [1:0] {
    WIDLE = 2'b00,
    WERASE = 2'b01,
    WPROG = 2'b10
  } wrState_t;

  typedef enum logic [1:0] {
    KIDLE = 2'b00,
    KGOT1 = 2'b01,
    KARMED = 2'b10
  } keyState_t;

  typedef struct packed {
    wrState_t wst;
    keyState_t kst;
    logic pgd;
    logic cfg;
    logic rowErase;
    logic err;
    logic write_enable;
    logic wr;
    logic rd;
    logic [1:0] adrHi;
    logic [7:0] adrLo;
    logic [7:0] data;
    logic [7:0] rdata;
    logic done;
    logic [19:0] tmr;
    logic [19:0] pwrt;
    logic pwrtDone;
  } state_t;

endpackage
`default_nettype wire

// ### test/data_eeprom_access_control_tb_top.sv
// Self-checking bench for the nonvolatile access controller
`include "nv_access_consts.svh"
`default_nettype none
module data_eeprom_access_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] regSel;
  logic regWr, doneClr, writeDoneFlag, writeBusy;
  logic [7:0] regWdata, regRdata;
  logic [1:0] spaceSel;
  logic [7:0] mem [1024];
  logic [9:0] adr [6];
  logic [31:0] seed = 32'h4021bddc;
  int miscompares = 0;
  int testsRun = 0;
  int busyCnt = 0;
  nv_access_ctrl #(.WRITE_CYCLES(8), .PWRT_CYCLES(4)) u_dut (.core_clk,
    .rst_n, .regSel, .regWr, .regWdata, .regRdata, .doneClr,
    .writeDoneFlag, .writeBusy, .spaceSel);
  nv_cpu_model u_cpu (.core_clk, .regSel, .regWr, .regWdata, .doneClr,
    .regRdata);
  initial forever #2 core_clk = ~core_clk;
  always @(posedge core_clk) if (writeBusy === 1'b1) busyCnt++;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] ctrlExp(logic p, c, e, w);
    return {p, c, 2'b00, e, w, 2'b00};
  endfunction
  task automatic chk(input logic [7:0] got, exp);
    testsRun++;
    if (got !== exp) begin
      miscompares++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdChk(input logic [2:0] s, input logic [7:0] exp);
    logic [7:0] d;
    u_cpu.rdReg(s, d);
    chk(d, exp);
  endtask
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    u_cpu.wrReg(s, d);
  endtask
  task automatic waitIdle();
    for (int i = 0; i < 30; i++) if (writeBusy === 1'b1) @(posedge core_clk) #1;
  endtask
  task automatic doWrite(input logic [9:0] a, input logic [7:0] d);
    wr(`NV_SEL_ADRH, {6'h2a, a[9:8]});
    wr(`NV_SEL_ADRL, a[7:0]);
    wr(`NV_SEL_DATA, d);
    wr(`NV_SEL_CTRL, 8'h04);
    busyCnt = 0;
    u_cpu.startWrite(8'h06);
    wr(`NV_SEL_DATA, ~d);
    wr(`NV_SEL_ADRL, ~a[7:0]);
    waitIdle();
    mem[a] = d;
  endtask
  task automatic note(string s);
    $display("test %s done", s);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #40000;
    miscompares++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rdChk(`NV_SEL_CTRL, ctrlExp(0, 0, 1, 0));
    rdChk(`NV_SEL_KEY, 8'h00);
    rdChk(3'h5, 8'h00);
    wr(`NV_SEL_ADRH, 8'hff);
    rdChk(`NV_SEL_ADRH, 8'h03);
    note("reset");
    adr[0] = 10'h3ff;
    adr[1] = 10'h000;
    adr[2] = 10'h3ff;
    for (int i = 3; i < 6; i++) adr[i] = 10'(rnd());
    foreach (adr[i]) begin
      doWrite(adr[i], 8'(rnd()));
      chk({7'h0, busyCnt inside {[7:10]}}, 8'h01);
      chk({7'h0, writeDoneFlag}, 8'h01);
      rdChk(`NV_SEL_DATA, mem[adr[i]]);
      rdChk(`NV_SEL_CTRL, ctrlExp(0, 0, 0, 1));
      u_cpu.clrDone();
      chk({7'h0, writeDoneFlag}, 8'h00);
    end
    wr(`NV_SEL_CTRL, 8'h00);
    foreach (adr[i]) begin
      wr(`NV_SEL_ADRH, {6'h00, adr[i][9:8]});
      wr(`NV_SEL_ADRL, adr[i][7:0]);
      wr(`NV_SEL_CTRL, 8'h01);
      rdChk(`NV_SEL_DATA, mem[adr[i]]);
    end
    rdChk(`NV_SEL_CTRL, 8'h00);
    note("write_read");
    wr(`NV_SEL_CTRL, 8'h04);
    wr(`NV_SEL_CTRL, 8'h06);
    chk({7'h0, writeBusy}, 8'h00);
    rdChk(`NV_SEL_CTRL, ctrlExp(0, 0, 1, 1));
    wr(`NV_SEL_KEY, `NV_KEY_FIRST);
    wr(`NV_SEL_ADRL, 8'h12);
    wr(`NV_SEL_KEY, `NV_KEY_SECOND);
    wr(`NV_SEL_CTRL, 8'h06);
    chk({7'h0, writeBusy}, 8'h00);
    wr(`NV_SEL_CTRL, 8'h00);
    u_cpu.startWrite(8'h06);
    chk({7'h0, writeBusy}, 8'h00);
    note("refused");
    wr(`NV_SEL_DATA, 8'h5a);
    wr(`NV_SEL_CTRL, 8'h81);
    chk({6'h0, spaceSel}, 8'h02);
    wr(`NV_SEL_CTRL, 8'h41);
    chk({6'h0, spaceSel}, 8'h01);
    rdChk(`NV_SEL_DATA, 8'h5a);
    wr(`NV_SEL_CTRL, 8'h20);
    rdChk(`NV_SEL_CTRL, 8'h00);
    wr(`NV_SEL_CTRL, 8'h84);
    wr(`NV_SEL_CTRL, 8'h86);
    chk({6'h0, spaceSel}, 8'h02);
    rdChk(`NV_SEL_CTRL, 8'h8c);
    wr(`NV_SEL_CTRL, 8'h94);
    u_cpu.startWrite(8'h96);
    chk({7'h0, writeBusy}, 8'h01);
    waitIdle();
    rdChk(`NV_SEL_CTRL, 8'h84);
    note("spaces");
    // Reset in the middle of a data write must abort it and flag the error
    wr(`NV_SEL_CTRL, 8'h04);
    u_cpu.startWrite(8'h06);
    chk({7'h0, writeBusy}, 8'h01);
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    chk({6'h0, writeBusy, writeDoneFlag}, 8'h00);
    rdChk(`NV_SEL_CTRL, ctrlExp(0, 0, 1, 0));
    note("reset_abort");
    conclude();
  end
endmodule // data_eeprom_access_control_tb_top
`default_nettype wire

// ### test/nv_cpu_model.sv
// Processor core model that drives the register port
`include "nv_access_consts.svh"
`default_nettype none
module nv_cpu_model (
  input wire logic core_clk, // Instruction clock
  output logic [2:0] regSel, // Register select
  output logic regWr, // Write strobe
  output logic [7:0] regWdata, // Write data
  output logic doneClr, // Clears write_done_flag
  input wire logic [7:0] regRdata // Read data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    regSel = 3'h0;
    regWr = 1'b0;
    regWdata = 8'h00;
    doneClr = 1'b0;
  end
  // Released data shows the inverse so stale values never look valid
  task automatic wrReg(input logic [2:0] s, input logic [7:0] d);
    @(posedge core_clk);
    regSel <= s;
    regWr <= 1'b1;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
    regWdata <= ~d;
    #1;
  endtask
  task automatic rdReg(input logic [2:0] s, output logic [7:0] d);
    @(posedge core_clk);
    regSel <= s;
    @(posedge core_clk);
    #1;
    d = regRdata;
  endtask
  // Keys must directly precede the start bit, once per byte
  task automatic startWrite(input logic [7:0] ctrl);
    wrReg(`NV_SEL_KEY, `NV_KEY_FIRST);
    wrReg(`NV_SEL_KEY, `NV_KEY_SECOND);
    wrReg(`NV_SEL_CTRL, ctrl);
  endtask
  task automatic clrDone();
    @(posedge core_clk);
    doneClr <= 1'b1;
    @(posedge core_clk);
    doneClr <= 1'b0;
    #1;
  endtask
endmodule // nv_cpu_model
`default_nettype wire
